// [hdl/uhl_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module uhl_regs
  import uhl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire uhl_pkg::uhl_bus_req_t busReq,
  output var logic [31:0] rdata,
  input wire logic bitTick,
  input wire uhl_pkg::uhl_engine_t engine,
  output var logic irqOut,
  output var logic startAllowed,
  output var logic [31:0] commAreaBase,
  output var logic [31:0] ctrlListFirst,
  output var logic [31:0] bulkListFirst,
  output var logic [31:0] ctrlListNow,
  output var logic [31:0] bulkListNow,
  output var logic frameBeginPulse
);
  typedef struct packed {
    logic [31:0] rdata;
    logic irq;
    logic startOk;
    logic frameBegin;
    logic [31:0] commBase;
    logic [31:0] periodicNow;
    logic [31:0] ctrlFirst;
    logic [31:0] ctrlNow;
    logic [31:0] bulkFirst;
    logic [31:0] bulkNow;
    logic [31:0] finished_queue_head;
    logic intervalToggle;
    logic [PKT_W-1:0] largestFsPacket;
    logic [FRAME_LEN_W-1:0] frameLength;
    logic [IRQ_SRC_W-1:0] flags;
    logic frameTopBit;
    uhl_done_state_t doneState;
  } uhl_reg_state_t;

  uhl_reg_state_t state_q;
  uhl_reg_state_t state_d;
  logic masterOn;
  logic [IRQ_SRC_W-1:0] srcOn;
  logic [FRAME_LEN_W-1:0] frameTimeLeft;
  logic remainingToggle;
  logic [FRAME_NUM_W-1:0] frameCountValue;
  logic frameStart;
  logic [IRQ_SRC_W-1:0] events;
  logic [IRQ_SRC_W-1:0] clearMask;

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  uhl_irq_enable uEnable (
    .clk_sys(clk_sys),
    .rst(rst),
    .setWr(busReq.wr && busReq.addr == ADDR_IRQ_ON),
    .clrWr(busReq.wr && busReq.addr == ADDR_IRQ_OFF),
    .wdata(busReq.wdata),
    .masterOn(masterOn),
    .srcOn(srcOn)
  );

  uhl_frame_timer uTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .bitTick(bitTick),
    .frameLength(state_q.frameLength),
    .intervalToggle(state_q.intervalToggle),
    .frameTimeLeft(frameTimeLeft),
    .remainingToggle(remainingToggle),
    .frameCountValue(frameCountValue),
    .frameStart(frameStart)
  );

  // ---------------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------------
  always_comb
  begin
    events = '0;
    events[BIT_OVERRUN] = engine.overrun;
    events[BIT_DONE_WRITE] = engine.doneWritten && state_q.doneState == DW_IDLE;
    events[BIT_FRAME_BEGIN] = frameStart;
    events[BIT_WAKE_SEEN] = engine.wakeSeen;
    events[BIT_FATAL_ERROR] = engine.fatalError;
    events[BIT_FRAME_WRAP] = frameCountValue[FRAME_NUM_W-1] != state_q.frameTopBit;
    events[BIT_HUB_CHANGE] = engine.hubChange;
    clearMask = '0;
    if (busReq.wr && busReq.addr == ADDR_EVENT_STATUS)
    begin
      clearMask = busReq.wdata[IRQ_SRC_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.frameTopBit = frameCountValue[FRAME_NUM_W-1];
    state_d.frameBegin = frameStart;
    // Set wins over a clear in the same cycle so no event is lost.
    state_d.flags = (state_q.flags & ~clearMask) | events;
    state_d.irq = masterOn && |(state_d.flags & srcOn);
    state_d.startOk = {1'b0, frameTimeLeft} > state_q.largestFsPacket;

    if (engine.periodicLoad)
    begin
      state_d.periodicNow = engine.periodicDesc & DESC_MASK;
    end
    if (engine.doneWritten && state_q.doneState == DW_IDLE)
    begin
      state_d.finished_queue_head = engine.doneDesc & DESC_MASK;
    end
    case (state_q.doneState)
      DW_IDLE:
      begin
        if (engine.doneWritten)
        begin
          state_d.doneState = DW_HELD;
        end
      end
      DW_HELD:
      begin
        if (!state_d.flags[BIT_DONE_WRITE])
        begin
          state_d.doneState = DW_IDLE;
        end
      end
      default:
      begin
        state_d.doneState = DW_IDLE;
      end
    endcase

    if (busReq.wr)
    begin
      case (busReq.addr)
        ADDR_COMM_BASE: state_d.commBase = busReq.wdata & COMM_BASE_MASK;
        ADDR_CTRL_FIRST: state_d.ctrlFirst = busReq.wdata & DESC_MASK;
        ADDR_CTRL_NOW: state_d.ctrlNow = busReq.wdata & DESC_MASK;
        ADDR_BULK_FIRST: state_d.bulkFirst = busReq.wdata & DESC_MASK;
        ADDR_BULK_NOW: state_d.bulkNow = busReq.wdata & DESC_MASK;
        ADDR_FRAME_CFG:
        begin
          state_d.intervalToggle = busReq.wdata[TOGGLE_BIT];
          state_d.largestFsPacket = busReq.wdata[PKT_LSB +: PKT_W];
          state_d.frameLength = busReq.wdata[FRAME_LEN_W-1:0];
        end
        default:
        begin
          state_d.commBase = state_d.commBase;
        end
      endcase
    end
    if (engine.ctrlLoad)
    begin
      state_d.ctrlNow = engine.ctrlDesc & DESC_MASK;
    end
    if (engine.bulkLoad)
    begin
      state_d.bulkNow = engine.bulkDesc & DESC_MASK;
    end

    state_d.rdata = ZERO_WORD;
    if (busReq.rd)
    begin
      case (busReq.addr)
        ADDR_IRQ_ON, ADDR_IRQ_OFF:
        begin
          state_d.rdata[MASTER_BIT] = masterOn;
          state_d.rdata[IRQ_SRC_W-1:0] = srcOn;
        end
        ADDR_COMM_BASE: state_d.rdata = state_q.commBase;
        ADDR_PERIODIC_NOW: state_d.rdata = state_q.periodicNow;
        ADDR_CTRL_FIRST: state_d.rdata = state_q.ctrlFirst;
        ADDR_CTRL_NOW: state_d.rdata = state_q.ctrlNow;
        ADDR_BULK_FIRST: state_d.rdata = state_q.bulkFirst;
        ADDR_BULK_NOW: state_d.rdata = state_q.bulkNow;
        ADDR_DONE_HEAD: state_d.rdata = state_q.finished_queue_head;
        ADDR_FRAME_CFG:
        begin
          state_d.rdata[TOGGLE_BIT] = state_q.intervalToggle;
          state_d.rdata[PKT_LSB +: PKT_W] = state_q.largestFsPacket;
          state_d.rdata[FRAME_LEN_W-1:0] = state_q.frameLength;
        end
        ADDR_FRAME_LEFT:
        begin
          state_d.rdata[TOGGLE_BIT] = remainingToggle;
          state_d.rdata[FRAME_LEN_W-1:0] = frameTimeLeft;
        end
        ADDR_FRAME_COUNT: state_d.rdata[FRAME_NUM_W-1:0] = frameCountValue;
        ADDR_EVENT_STATUS: state_d.rdata[IRQ_SRC_W-1:0] = state_q.flags;
        default: state_d.rdata = ZERO_WORD;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= '0;
      state_q.frameLength <= FRAME_LEN_RESET;
      state_q.largestFsPacket <= PKT_RESET;
      state_q.doneState <= DW_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign irqOut = state_q.irq;
  assign startAllowed = state_q.startOk;
  assign commAreaBase = state_q.commBase;
  assign ctrlListFirst = state_q.ctrlFirst;
  assign bulkListFirst = state_q.bulkFirst;
  assign ctrlListNow = state_q.ctrlNow;
  assign bulkListNow = state_q.bulkNow;
  assign frameBeginPulse = state_q.frameBegin;
endmodule
`default_nettype wire

// [hdl/uhl_pkg.sv]
package uhl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_IRQ_ON = 32'h4002_0010;
  localparam logic [31:0] ADDR_IRQ_OFF = 32'h4002_0014;
  localparam logic [31:0] ADDR_COMM_BASE = 32'h4002_0018;
  localparam logic [31:0] ADDR_PERIODIC_NOW = 32'h4002_001c;
  localparam logic [31:0] ADDR_CTRL_FIRST = 32'h4002_0020;
  localparam logic [31:0] ADDR_CTRL_NOW = 32'h4002_0024;
  localparam logic [31:0] ADDR_BULK_FIRST = 32'h4002_0028;
  localparam logic [31:0] ADDR_BULK_NOW = 32'h4002_002c;
  localparam logic [31:0] ADDR_DONE_HEAD = 32'h4002_0030;
  localparam logic [31:0] ADDR_FRAME_CFG = 32'h4002_0034;
  localparam logic [31:0] ADDR_FRAME_LEFT = 32'h4002_0038;
  localparam logic [31:0] ADDR_FRAME_COUNT = 32'h4002_003c;
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h4002_0060;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int IRQ_SRC_W = 7;
  localparam int MASTER_BIT = 31;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_DONE_WRITE = 1;
  localparam int BIT_FRAME_BEGIN = 2;
  localparam int BIT_WAKE_SEEN = 3;
  localparam int BIT_FATAL_ERROR = 4;
  localparam int BIT_FRAME_WRAP = 5;
  localparam int BIT_HUB_CHANGE = 6;
  localparam int TOGGLE_BIT = 31;
  localparam int FRAME_LEN_W = 14;
  localparam int PKT_LSB = 16;
  localparam int PKT_W = 15;
  localparam int FRAME_NUM_W = 16;
  localparam logic [31:0] COMM_BASE_MASK = 32'hffff_ff00;
  localparam logic [31:0] DESC_MASK = 32'hffff_fff0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [13:0] FRAME_LEN_RESET = 14'h2edf;
  localparam logic [14:0] PKT_RESET = 15'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhl_bus_req_t;

  typedef struct packed {
    logic [31:0] periodicDesc;
    logic periodicLoad;
    logic [31:0] ctrlDesc;
    logic ctrlLoad;
    logic [31:0] bulkDesc;
    logic bulkLoad;
    logic [31:0] doneDesc;
    logic doneWritten;
    logic hubChange;
    logic fatalError;
    logic wakeSeen;
    logic overrun;
  } uhl_engine_t;

  typedef enum logic [1:0] {
    DW_IDLE,
    DW_HELD
  } uhl_done_state_t;

endpackage

// [hdl/uhl_irq_enable.sv]
`timescale 1ns/10ps
`default_nettype none
module uhl_irq_enable
  import uhl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic setWr,
  input wire logic clrWr,
  input wire logic [31:0] wdata,
  output var logic masterOn,
  output var logic [uhl_pkg::IRQ_SRC_W-1:0] srcOn
);
  typedef struct packed {
    logic master;
    logic [IRQ_SRC_W-1:0] src;
  } uhl_en_state_t;

  uhl_en_state_t state_q;
  uhl_en_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (setWr)
    begin
      state_d.master = state_q.master | wdata[MASTER_BIT];
      state_d.src = state_q.src | wdata[IRQ_SRC_W-1:0];
    end
    if (clrWr)
    begin
      state_d.master = state_d.master & ~wdata[MASTER_BIT];
      state_d.src = state_d.src & ~wdata[IRQ_SRC_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign masterOn = state_q.master;
  assign srcOn = state_q.src;
endmodule
`default_nettype wire

// [hdl/uhl_frame_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module uhl_frame_timer
  import uhl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bitTick,
  input wire logic [uhl_pkg::FRAME_LEN_W-1:0] frameLength,
  input wire logic intervalToggle,
  output var logic [uhl_pkg::FRAME_LEN_W-1:0] frameTimeLeft,
  output var logic remainingToggle,
  output var logic [uhl_pkg::FRAME_NUM_W-1:0] frameCountValue,
  output var logic frameStart
);
  typedef struct packed {
    logic [FRAME_LEN_W-1:0] left;
    logic toggle;
    logic [FRAME_NUM_W-1:0] count;
    logic start;
  } uhl_timer_state_t;

  uhl_timer_state_t state_q;
  uhl_timer_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.start = 1'b0;
    if (bitTick)
    begin
      if (state_q.left == '0)
      begin
        state_d.left = frameLength;
        state_d.toggle = intervalToggle;
        state_d.count = state_q.count + 1'b1;
        state_d.start = 1'b1;
      end
      else
      begin
        state_d.left = state_q.left - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign frameTimeLeft = state_q.left;
  assign remainingToggle = state_q.toggle;
  assign frameCountValue = state_q.count;
  assign frameStart = state_q.start;
endmodule
`default_nettype wire

// [testbench/uhl_regs_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks
// ----
module uhl_regs_monitor
  import uhl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire uhl_pkg::uhl_bus_req_t busReq,
  input wire logic [31:0] rdata,
  input wire logic bitTick,
  input wire uhl_pkg::uhl_engine_t engine,
  input wire logic irqOut,
  input wire logic startAllowed,
  input wire logic [31:0] commAreaBase,
  input wire logic [31:0] ctrlListFirst,
  input wire logic [31:0] bulkListFirst,
  input wire logic [31:0] ctrlListNow,
  input wire logic [31:0] bulkListNow,
  input wire logic frameBeginPulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence offMaster;
    busReq.wr && busReq.addr == ADDR_IRQ_OFF && busReq.wdata[MASTER_BIT];
  endsequence
  // A set write right after would legally raise the master again.
  sequence noSetWrite;
    !(busReq.wr && busReq.addr == ADDR_IRQ_ON);
  endsequence
  AST_MASTER_OFF:
    assert property (offMaster ##1 noSetWrite |-> ##1 !irqOut) else $error("irq after off");
  AST_COMM_LOW:
    assert property (commAreaBase[7:0] == 8'h00) else $error("base low byte set");
  AST_RD_BASE:
    assert property (busReq.rd && busReq.addr == ADDR_COMM_BASE |=> rdata == commAreaBase)
    else $error("base read mismatch");
  AST_CTRL_HEAD:
    assert property (busReq.wr && busReq.addr == ADDR_CTRL_FIRST
      |=> ctrlListFirst == ($past(busReq.wdata) & DESC_MASK)) else $error("ctrl head");
  AST_CTRL_HOLD:
    assert property (!(busReq.wr && busReq.addr == ADDR_CTRL_FIRST) |=> $stable(ctrlListFirst))
    else $error("ctrl head moved");
  AST_BULK_HEAD:
    assert property (busReq.wr && busReq.addr == ADDR_BULK_FIRST
      |=> bulkListFirst == ($past(busReq.wdata) & DESC_MASK)) else $error("bulk head");
  AST_CTRL_LOAD:
    assert property (engine.ctrlLoad |=> ctrlListNow == ($past(engine.ctrlDesc) & DESC_MASK))
    else $error("ctrl current");
  AST_BULK_LOAD:
    assert property (engine.bulkLoad |=> bulkListNow == ($past(engine.bulkDesc) & DESC_MASK))
    else $error("bulk current");
  AST_FRAME_TICK:
    assert property (frameBeginPulse |-> $past(bitTick, 2)) else $error("reload without tick");
endmodule
bind uhl_regs uhl_regs_monitor u_mon (.clk_sys, .rst, .busReq, .rdata, .bitTick, .engine,
  .irqOut, .startAllowed, .commAreaBase, .ctrlListFirst, .bulkListFirst, .ctrlListNow,
  .bulkListNow, .frameBeginPulse);
`default_nettype wire

// [testbench/test_usb_host_list_frame_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module test_usb_host_list_frame_regs;
  import uhl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  uhl_bus_req_t busReq = '0;
  uhl_engine_t engine = '0;
  logic bitTick = 1'b0;
  logic [31:0] rdata;
  logic irqOut;
  logic startAllowed;
  logic [31:0] commAreaBase;
  logic [31:0] ctrlListFirst;
  logic [31:0] bulkListFirst;
  logic [31:0] ctrlListNow;
  logic [31:0] bulkListNow;
  logic frameBeginPulse;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] v;
  always #10 clk_sys = ~clk_sys;
  uhl_regs u_dut (.clk_sys, .rst, .busReq, .rdata, .bitTick, .engine, .irqOut, .startAllowed,
    .commAreaBase, .ctrlListFirst, .bulkListFirst, .ctrlListNow, .bulkListNow,
    .frameBeginPulse);
  task automatic results();
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The frame wrap run dominates; the ceiling leaves room above it.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse(input uhl_engine_t e);
    @(posedge clk_sys);
    engine <= e;
    @(posedge clk_sys);
    engine <= '0;
  endtask
  task automatic irqIs(input logic e);
    @(posedge clk_sys);
    #1;
    chk(32'(irqOut), 32'(e));
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys);
    bitTick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    bitTick <= 1'b0;
  endtask
  // ----
  // Stimulus
  // ----
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_COMM_BASE, 32'h0);
    rd(ADDR_CTRL_FIRST, 32'h0);
    rd(ADDR_BULK_FIRST, 32'h0);
    rd(ADDR_IRQ_ON, 32'h0);
    rd(ADDR_FRAME_CFG, 32'h0000_2edf);
    v = 32'h0;
    for (int i = 0; i < IRQ_SRC_W; i++)
    begin
      wr(ADDR_IRQ_ON, 32'h1 << i);
      v[i] = 1'b1;
      rd(ADDR_IRQ_ON, v);
    end
    wr(ADDR_IRQ_ON, 32'h0);
    rd(ADDR_IRQ_OFF, 32'h7f);
    wr(ADDR_IRQ_OFF, 32'h55);
    rd(ADDR_IRQ_ON, 32'h2a);
    wr(ADDR_IRQ_ON, 32'h8000_0001);
    rd(ADDR_IRQ_ON, 32'h8000_002b);
    pulse('{overrun: 1'b1, default: '0});
    irqIs(1'b1);
    wr(ADDR_IRQ_OFF, 32'h8000_0000);
    irqIs(1'b0);
    rd(ADDR_IRQ_ON, 32'h2b);
    wr(ADDR_IRQ_ON, 32'h8000_0000);
    irqIs(1'b1);
    rd(ADDR_EVENT_STATUS, 32'h1);
    wr(ADDR_EVENT_STATUS, 32'h1);
    irqIs(1'b0);
    pulse('{hubChange: 1'b1, default: '0});
    irqIs(1'b0);
    rd(ADDR_EVENT_STATUS, 32'h40);
    wr(ADDR_EVENT_STATUS, 32'h40);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL_FIRST + 32'(4 * i), 32'ha5a5_a5af);
      rd(ADDR_CTRL_FIRST + 32'(4 * i), 32'ha5a5_a5a0);
    end
    chk(ctrlListFirst & bulkListFirst & ctrlListNow & bulkListNow, 32'ha5a5_a5a0);
    wr(ADDR_CTRL_NOW, 32'h0);
    rd(ADDR_CTRL_NOW, 32'h0);
    wr(ADDR_BULK_NOW, 32'h0);
    rd(ADDR_BULK_NOW, 32'h0);
    wr(ADDR_COMM_BASE, 32'hffff_ffff);
    rd(ADDR_COMM_BASE, 32'hffff_ff00);
    chk(commAreaBase, 32'hffff_ff00);
    pulse('{ctrlLoad: 1'b1, ctrlDesc: 32'h1234_5678, default: '0});
    rd(ADDR_CTRL_NOW, 32'h1234_5670);
    pulse('{bulkLoad: 1'b1, bulkDesc: 32'h8765_432f, default: '0});
    rd(ADDR_BULK_NOW, 32'h8765_4320);
    pulse('{periodicLoad: 1'b1, periodicDesc: 32'h0bad_f00d, default: '0});
    wr(ADDR_PERIODIC_NOW, 32'h0);
    rd(ADDR_PERIODIC_NOW, 32'h0bad_f000);
    pulse('{doneWritten: 1'b1, doneDesc: 32'h1110, default: '0});
    rd(ADDR_DONE_HEAD, 32'h1110);
    pulse('{doneWritten: 1'b1, doneDesc: 32'h2220, default: '0});
    rd(ADDR_DONE_HEAD, 32'h1110);
    rd(ADDR_EVENT_STATUS, 32'h2);
    wr(ADDR_EVENT_STATUS, 32'h2);
    pulse('{doneWritten: 1'b1, doneDesc: 32'h2220, default: '0});
    rd(ADDR_DONE_HEAD, 32'h2220);
    rd(32'h4002_0004, 32'h0);
    wr(ADDR_FRAME_CFG, 32'h8001_0003);
    rd(ADDR_FRAME_CFG, 32'h8001_0003);
    ticks(1);
    rd(ADDR_FRAME_LEFT, 32'h8000_0003);
    rd(ADDR_FRAME_COUNT, 32'h1);
    chk(32'(startAllowed), 32'h1);
    ticks(2);
    rd(ADDR_FRAME_LEFT, 32'h8000_0001);
    chk(32'(startAllowed), 32'h0);
    wr(ADDR_FRAME_CFG, 32'h0);
    rd(ADDR_FRAME_LEFT, 32'h8000_0001);
    ticks(2);
    rd(ADDR_FRAME_LEFT, 32'h0);
    rd(ADDR_FRAME_COUNT, 32'h2);
    // A zero frame length reloads on every tick, so the wrap comes quickly.
    ticks(32766);
    rd(ADDR_FRAME_COUNT, 32'h8000);
    rd(ADDR_EVENT_STATUS, 32'h26);
    results();
  end
endmodule
`default_nettype wire
